// *** src/plut_top.sv ***
// programmable lookup slice: four register-held truth tables drive i/o pins
// assumes: register port strobes and pin inputs are synchronous to clk
// assumes: mode inputs are held steady by the owner of the mode registers, outside this slice

// Behaviour
// - io 15 is driven with the bank b high table bit indexed by io 14..12.
// - the io 15 lookup acts only while bank b upper mode is three-to-one.
// - io 7 is driven with the bank a high table bit indexed by io 6..4.
// - the io 7 lookup acts only while bank a upper mode is three-to-one.
// - io 2 takes bit 0 of the bank a low two-input table when io 1..0 is 00.
// - io 11 takes bit 7 of the table at 0x26 when io 10..8 is 111.
// - every table register clears to zero at reset so all lookups give low.
// - the bank a low two-input table acts only while bank a lower mode is two-to-one.
// - the table at 0x26 acts only while bank b lower mode is three-to-one.
module plut_top
  import plut_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata_r,
  input  wire logic [1:0] logic_mode_bank_b_upper,
  input  wire logic [1:0] logic_mode_bank_a_upper,
  input  wire logic [1:0] logic_mode_bank_a_lower,
  input  wire logic [1:0] logic_mode_bank_b_lower,
  input  wire logic [15:0] io_in,
  output logic      [15:0] io_out_r,
  output logic      [15:0] io_oe_r
);

  // --------------------------------------------------------------------------
  // table registers
  // --------------------------------------------------------------------------
  logic [7:0] bank_a_low_two_input_table_r;
  logic [7:0] bank_b_high_three_input_table_r;
  logic [7:0] bank_a_high_three_input_table_r;
  logic [7:0] bank_b_low_three_input_table_r;

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  // one hit per table; offsets outside the map hit nothing and are dropped silently
  logic wr_hit_a_low_two;
  logic wr_hit_b_high_three;
  logic wr_hit_a_high_three;
  logic wr_hit_b_low_three;

  always_comb begin
    wr_hit_a_low_two    = reg_we && (reg_addr == PLUT_OFS_BANK_A_LOW_TWO);
    wr_hit_b_high_three = reg_we && (reg_addr == PLUT_OFS_BANK_B_HIGH_THREE);
    wr_hit_a_high_three = reg_we && (reg_addr == PLUT_OFS_BANK_A_HIGH_THREE);
    wr_hit_b_low_three  = reg_we && (reg_addr == PLUT_OFS_BANK_B_LOW_THREE);
  end

  // bank a low table, feeds io 2; the whole byte is kept so it reads back as written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_a_low_two_input_table_r <= PLUT_TABLE_RST;
    end else if (wr_hit_a_low_two) begin
      bank_a_low_two_input_table_r <= reg_wdata;
    end
  end

  // bank b high table, feeds io 15
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_b_high_three_input_table_r <= PLUT_TABLE_RST;
    end else if (wr_hit_b_high_three) begin
      bank_b_high_three_input_table_r <= reg_wdata;
    end
  end

  // bank a high table, feeds io 7
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_a_high_three_input_table_r <= PLUT_TABLE_RST;
    end else if (wr_hit_a_high_three) begin
      bank_a_high_three_input_table_r <= reg_wdata;
    end
  end

  // bank b low table, feeds io 11
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_b_low_three_input_table_r <= PLUT_TABLE_RST;
    end else if (wr_hit_b_low_three) begin
      bank_b_low_three_input_table_r <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------------
  // unmapped offsets read as zero
  logic [7:0] reg_rdata_nxt;

  always_comb begin
    case (reg_addr)
      PLUT_OFS_BANK_A_LOW_TWO:    reg_rdata_nxt = bank_a_low_two_input_table_r;
      PLUT_OFS_BANK_B_HIGH_THREE: reg_rdata_nxt = bank_b_high_three_input_table_r;
      PLUT_OFS_BANK_A_HIGH_THREE: reg_rdata_nxt = bank_a_high_three_input_table_r;
      PLUT_OFS_BANK_B_LOW_THREE:  reg_rdata_nxt = bank_b_low_three_input_table_r;
      default:                    reg_rdata_nxt = PLUT_RDATA_UNMAPPED;
    endcase
  end

  // read data holds until the next read strobe; a read in the cycle of a write to the
  // same table returns the old byte, the new one is seen from the next cycle on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_re) begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // select pins and mode gates
  // --------------------------------------------------------------------------
  // select value is the pin group read as binary, lowest pin number as lsb
  logic [2:0] sel_b_high;
  logic [2:0] sel_a_high;
  logic [1:0] sel_a_low;
  logic [2:0] sel_b_low;
  logic       en_b_high;
  logic       en_a_high;
  logic       en_a_low;
  logic       en_b_low;

  always_comb begin
    sel_b_high = io_in[PLUT_PIN_B_HIGH_SEL +: 3];
    sel_a_high = io_in[PLUT_PIN_A_HIGH_SEL +: 3];
    sel_a_low  = io_in[PLUT_PIN_A_LOW_SEL +: 2];
    sel_b_low  = io_in[PLUT_PIN_B_LOW_SEL +: 3];
  end

  // a lookup owns its pin only in its own mode; in every other mode the
  // table still holds its byte but has no effect on the pin
  always_comb begin
    en_b_high = (logic_mode_bank_b_upper == PLUT_MODE_THREE_TO_ONE);
    en_a_high = (logic_mode_bank_a_upper == PLUT_MODE_THREE_TO_ONE);
    en_a_low  = (logic_mode_bank_a_lower == PLUT_MODE_TWO_TO_ONE);
    en_b_low  = (logic_mode_bank_b_lower == PLUT_MODE_THREE_TO_ONE);
  end

  // --------------------------------------------------------------------------
  // lookups: 0 = b high, 1 = a high, 2 = a low, 3 = b low
  // --------------------------------------------------------------------------
  logic [7:0] lut_table [PLUT_NUM_LUT];
  logic [2:0] lut_sel   [PLUT_NUM_LUT];
  logic [3:0] lut_en;
  logic [3:0] lut_bit;
  int         lut_pin   [PLUT_NUM_LUT];

  always_comb begin
    lut_table[0] = bank_b_high_three_input_table_r;
    lut_sel[0]   = sel_b_high;
    lut_en[0]    = en_b_high;
    lut_pin[0]   = PLUT_PIN_B_HIGH_OUT;
    lut_table[1] = bank_a_high_three_input_table_r;
    lut_sel[1]   = sel_a_high;
    lut_en[1]    = en_a_high;
    lut_pin[1]   = PLUT_PIN_A_HIGH_OUT;
    // two-input table: upper nibble belongs to io 6 in the other upper mode
    lut_table[2] = {4'h0, bank_a_low_two_input_table_r[3:0]};
    lut_sel[2]   = {1'b0, sel_a_low};
    lut_en[2]    = en_a_low;
    lut_pin[2]   = PLUT_PIN_A_LOW_OUT;
    lut_table[3] = bank_b_low_three_input_table_r;
    lut_sel[3]   = sel_b_low;
    lut_en[3]    = en_b_low;
    lut_pin[3]   = PLUT_PIN_B_LOW_OUT;
  end

  // each selector sits behind its own bundle so the four lookups stay identical
  genvar g;
  generate
    for (g = 0; g < PLUT_NUM_LUT; g++) begin : g_lut
      plut_sel_if lut_bus ();
      assign lut_bus.table_bits = lut_table[g];
      assign lut_bus.sel        = lut_sel[g];
      assign lut_bit[g]         = lut_bus.result;
      plut_sel u_sel (
        .lut (lut_bus.selector)
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // pin drive, registered; pins outside an active mode are neither driven nor enabled
  // --------------------------------------------------------------------------
  logic [15:0] io_out_nxt;
  logic [15:0] io_oe_nxt;
  // every lookup owns a distinct pin, so the loop below never drives one pin twice

  always_comb begin
    io_out_nxt = 16'h0000;
    io_oe_nxt  = 16'h0000;
    for (int i = 0; i < PLUT_NUM_LUT; i++) begin
      if (lut_en[i]) begin
        io_out_nxt[lut_pin[i]] = lut_bit[i];
        io_oe_nxt[lut_pin[i]]  = 1'b1;
      end
    end
  end

  // one cycle from pins to pins; a table write shows on its pin two cycles after
  // the strobe, traded for outputs that come straight from flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_out_r <= 16'h0000;
      io_oe_r  <= 16'h0000;
    end else begin
      io_out_r <= io_out_nxt;
      io_oe_r  <= io_oe_nxt;
    end
  end

endmodule : plut_top

// *** src/plut_pkg.sv ***
// package for the programmable lookup slice: register offsets, reset values, modes
// assumes: registers are reached through the device's own byte-wide register port
package plut_pkg;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] PLUT_OFS_BANK_A_LOW_TWO   = 8'h23;
  localparam logic [7:0] PLUT_OFS_BANK_B_HIGH_THREE = 8'h24;
  localparam logic [7:0] PLUT_OFS_BANK_A_HIGH_THREE = 8'h25;
  localparam logic [7:0] PLUT_OFS_BANK_B_LOW_THREE  = 8'h26;
  localparam logic [7:0] PLUT_TABLE_RST            = 8'h00;
  localparam logic [7:0] PLUT_RDATA_UNMAPPED       = 8'h00;

  // --------------------------------------------------------------------------
  // pin positions of each lookup (output pin, lowest select pin)
  // --------------------------------------------------------------------------
  localparam int PLUT_PIN_B_HIGH_OUT = 15;
  localparam int PLUT_PIN_B_HIGH_SEL = 12;
  localparam int PLUT_PIN_A_HIGH_OUT = 7;
  localparam int PLUT_PIN_A_HIGH_SEL = 4;
  localparam int PLUT_PIN_A_LOW_OUT  = 2;
  localparam int PLUT_PIN_A_LOW_SEL  = 0;
  localparam int PLUT_PIN_B_LOW_OUT  = 11;
  localparam int PLUT_PIN_B_LOW_SEL  = 8;
  localparam int PLUT_NUM_LUT        = 4;

  // --------------------------------------------------------------------------
  // logic mode of one quarter bank
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PLUT_MODE_OFF,
    PLUT_MODE_TWO_TO_ONE,
    PLUT_MODE_THREE_TO_ONE,
    PLUT_MODE_THREE_TO_TWO
  } plut_mode_t;

endpackage : plut_pkg

// *** src/plut_sel_if.sv ***
// bundle between the top and one table selector
// assumes: the selector is purely combinational
interface plut_sel_if;
  logic [7:0] table_bits;
  logic [2:0] sel;
  logic       result;

  modport owner    (output table_bits, output sel, input result);
  modport selector (input table_bits, input sel, output result);
endinterface : plut_sel_if

// *** src/plut_sel.sv ***
// one truth-table selector: picks the table bit indexed by the select pins
// assumes: unused upper table bits are tied low by the owner for two-input tables
module plut_sel (
  plut_sel_if.selector lut
);

  always_comb begin
    lut.result = lut.table_bits[lut.sel];
  end

endmodule : plut_sel

// *** tb/plut_props.sv ***
// checker for the lookup slice: pin enables, idle pins, reset and read data hold
// assumes: bound to plut_top, one clock with a synchronous reset
module plut_props
  import plut_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_re,
  input wire logic [7:0]  reg_rdata_r,
  input wire logic [1:0]  logic_mode_bank_b_upper,
  input wire logic [1:0]  logic_mode_bank_a_upper,
  input wire logic [1:0]  logic_mode_bank_a_lower,
  input wire logic [1:0]  logic_mode_bank_b_lower,
  input wire logic [15:0] io_out_r,
  input wire logic [15:0] io_oe_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_b_hi_gate: assert property (!sys_rst |=> io_oe_r[15] ==
    ($past(logic_mode_bank_b_upper) == PLUT_MODE_THREE_TO_ONE)) else $error("bad io15 enable");
  chk_a_hi_gate: assert property (!sys_rst |=> io_oe_r[7] ==
    ($past(logic_mode_bank_a_upper) == PLUT_MODE_THREE_TO_ONE)) else $error("bad io7 enable");
  chk_a_lo_gate: assert property (!sys_rst |=> io_oe_r[2] ==
    ($past(logic_mode_bank_a_lower) == PLUT_MODE_TWO_TO_ONE)) else $error("bad io2 enable");
  chk_b_lo_gate: assert property (!sys_rst |=> io_oe_r[11] ==
    ($past(logic_mode_bank_b_lower) == PLUT_MODE_THREE_TO_ONE)) else $error("bad io11 enable");
  chk_idle_pins: assert property (((io_oe_r | io_out_r) & 16'h777B) == 16'h0000)
    else $error("pin outside the slice driven");
  chk_out_gated: assert property ((io_out_r & ~io_oe_r) == 16'h0000)
    else $error("output high while not driven");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
    (io_oe_r == 16'h0000) && (io_out_r == 16'h0000) && (reg_rdata_r == 8'h00))
    else $error("not cleared by reset");
  chk_read_hold: assert property (!reg_re |=> $stable(reg_rdata_r))
    else $error("read data moved without a read");
endmodule : plut_props

bind plut_top plut_props i_plut_props (.clk(clk), .sys_rst(sys_rst), .reg_re(reg_re),
  .reg_rdata_r(reg_rdata_r), .logic_mode_bank_b_upper(logic_mode_bank_b_upper),
  .logic_mode_bank_a_upper(logic_mode_bank_a_upper), .io_out_r(io_out_r),
  .logic_mode_bank_a_lower(logic_mode_bank_a_lower), .io_oe_r(io_oe_r),
  .logic_mode_bank_b_lower(logic_mode_bank_b_lower));

// *** tb/tb.sv ***
// bench for the lookup slice: register reads and writes, select and mode sweeps
// assumes: plut_top and its checker are compiled first
module tb import plut_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, sys_rst, reg_we, reg_re;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_r;
  logic [1:0]  mode_bu, mode_au, mode_al, mode_bl;
  logic [15:0] io_in, io_out_r, io_oe_r;
  logic [7:0]  tv [4];
  logic [7:0]  ofs [4] = '{PLUT_OFS_BANK_B_HIGH_THREE, PLUT_OFS_BANK_A_HIGH_THREE,
                           PLUT_OFS_BANK_B_LOW_THREE, PLUT_OFS_BANK_A_LOW_TWO};
  int          failures, cmp_count, cyc;
  plut_top i_plut_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .reg_re(reg_re), .reg_rdata_r(reg_rdata_r), .io_in(io_in),
    .logic_mode_bank_b_upper(mode_bu), .logic_mode_bank_a_upper(mode_au),
    .logic_mode_bank_a_lower(mode_al), .logic_mode_bank_b_lower(mode_bl),
    .io_out_r(io_out_r), .io_oe_r(io_oe_r));
  always #12.5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 check({8'h00, reg_rdata_r}, {8'h00, exp});
  endtask : rd_chk
  // every three-input lookup sees the same select value, the two-input one its low two bits; pins 15, 11, 7, 2 held high as inputs
  task automatic pins(input logic [2:0] s, input logic [1:0] m3, input logic [1:0] m2);
    logic e3, e2;
    e3 = (m3 == PLUT_MODE_THREE_TO_ONE);
    e2 = (m2 == PLUT_MODE_TWO_TO_ONE);
    @(posedge clk);
    {mode_bu, mode_au, mode_bl, mode_al} <= {m3, m3, m3, m2};
    io_in <= {1'b1, s, 1'b1, s, 1'b1, s, 2'b11, s[1:0]};
    repeat (2) @(posedge clk);
    #1 check(io_oe_r, {e3, 3'h0, e3, 3'h0, e3, 4'h0, e2, 2'h0});
    check(io_out_r, {e3 & tv[0][s], 3'h0, e3 & tv[2][s], 3'h0, e3 & tv[1][s], 4'h0,
      e2 & tv[3][s[1:0]], 2'h0});
  endtask : pins
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // the whole run needs about 85 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {clk, sys_rst, reg_we, reg_re, reg_addr, reg_wdata} = {2'b01, 2'b00, 16'h0000};
    {mode_bu, mode_au, mode_al, mode_bl, io_in} = 24'h000000;
    tv = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 'h23; a <= 'h27; a++) rd_chk(8'(a), PLUT_TABLE_RST);
    pins(3'h7, PLUT_MODE_THREE_TO_ONE, PLUT_MODE_TWO_TO_ONE);
    tv = '{8'h96, 8'h9C, 8'h83, 8'h09};
    for (int k = 0; k < 4; k++) wr(ofs[k], tv[k]);
    for (int k = 0; k < 4; k++) rd_chk(ofs[k], tv[k]);
    for (int s = 0; s < 8; s++) pins(3'(s), PLUT_MODE_THREE_TO_ONE, PLUT_MODE_TWO_TO_ONE);
    for (int m = 0; m < 4; m++) pins(3'h7, 2'(m), 2'(m));
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd_chk(ofs[k], PLUT_TABLE_RST);
    tv = '{8'h00, 8'h00, 8'h00, 8'h00};
    pins(3'h7, PLUT_MODE_THREE_TO_ONE, PLUT_MODE_TWO_TO_ONE);
    summarize();
  end
endmodule : tb
